// ==== logic/sltx_ctrl_regs.sv ====
// Serial link transmit control registers on a classic Wishbone slave
//
// Overview of operation
// - Software sync bit resets to one; zero asserts sync request until set.
// - Software sync request works with every sync source selection.
// - Low selected pin keeps request; software alone releases with source 2 or reserved 3, or timestamp source with receiver off.
// - Lower lane map, the reset state, uses lanes 0 to count minus one.
// - Upper lane map uses lanes 4 to 4 plus count minus one.
// - Sync source: 0 dedicated input, 1 timestamp input with receiver, 2 software.
// - Sample format bit: zero offset binary, one (reset) two's complement.
// - Scrambler bit, reset one, enables 8B/10B scrambling; only 8B/10B modes.
// - 64B/66B modes always scramble and ignore the scrambler bit.
// - Test codes 1, 2, 3 give PRBS7, PRBS15, PRBS23; zero is normal.
// - Test codes 13 and 14 give PRBS9 and PRBS31.
// - Codes 4-9 and 16: ramp, transport, D21.5, K28.5, ILA, RPAT, K28.7.
// - Code 10 holds lanes low, 11 high, 15 sends clock word 0x00FF.
// - Device identifier register goes into second multiframe of lane alignment.
// - Link enable low holds link in reset, serdes down, clocks gated, counter held.
//
// The Wishbone register port was chosen for this implementation.
`default_nettype none
module sltx_ctrl_regs
   import sltx_pkg::*;
#(
   parameter int NUM_LANES = LANES
)
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   output logic [DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic dedicated_sync_n_i,
   input wire logic timestamp_sync_n_i,
   input wire logic timestamp_receiver_enable_i,
   input wire logic mode_is_64b66b_i,
   input wire logic [LCNT_W-1:0] lane_count_i,
   output logic sync_request_n_o,
   output sltx_link_s link_cfg_o,
   output sltx_test_s test_cfg_o
);

   // Lane mask for a lane count, optionally shifted to the upper lanes
   function automatic logic [LANES-1:0] lane_mask_f(
      input logic [LCNT_W-1:0] cnt,
      input logic upper
   );
      logic [LANES-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_LANES; i++) begin
         if (upper) begin
            m[i] = (i >= ALT_LANE_BASE) && (i - ALT_LANE_BASE < int'(cnt));
         end else begin
            m[i] = i < int'(cnt);
         end
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic link_enable_r;
   logic sw_sync_request_n_r;
   logic [CTRL_W-1:0] link_control_r;
   logic [TEST_W-1:0] test_pattern_sel_r;
   logic [REG_W-1:0] link_device_identifier_r;
   logic ack_r;
   logic [DAT_W-1:0] rd_data_r;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; one access is taken per request, ack follows one cycle later
   wire logic [IDX_W-1:0] idx = wb_adr_i[ADR_W-1:2];
   wire logic req = wb_cyc_i && wb_stb_i && !ack_r;
   wire logic wr = req && wb_we_i && wb_sel_i[0];
   wire logic [REG_W-1:0] wbyte = wb_dat_i[REG_W-1:0];
   wire logic wr_en = wr && idx == IDX_LINK_EN;
   wire logic wr_sync = wr && idx == IDX_SW_SYNC;
   wire logic wr_ctrl = wr && idx == IDX_CTRL;
   wire logic wr_test = wr && idx == IDX_TEST;
   wire logic wr_did = wr && idx == IDX_DID;

   // Named control fields
   wire logic scrambler_enable = link_control_r[CTRL_SCR_BIT];
   wire logic sample_format_sel = link_control_r[CTRL_FMT_BIT];
   wire logic [1:0] sync_src = link_control_r[CTRL_SYNC_LSB +: 2];
   wire logic upper_lane_map_sel = link_control_r[CTRL_ALT_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Sync source selection; reserved value 3 behaves like software only
   wire logic pin_sync_n =
      (sync_src == SYNC_SRC_DEDICATED) ? dedicated_sync_n_i :
      (sync_src == SYNC_SRC_TIMESTAMP) ?
         (timestamp_sync_n_i || !timestamp_receiver_enable_i) :
      1'b1;
   // Either source low asserts the request, so a stuck pin wins
   wire logic sync_n_nxt = pin_sync_n && sw_sync_request_n_r;

   ////////////////////////////////////////////////////////////////////////////
   // Link configuration; a disabled link keeps every lane dark
   sltx_link_s link_nxt;
   always_comb begin
      link_nxt = '0;
      link_nxt.link_reset = !link_enable_r;
      link_nxt.serdes_power_down = !link_enable_r;
      link_nxt.clock_gate = !link_enable_r;
      link_nxt.mf_counter_hold = !link_enable_r;
      link_nxt.sample_twos_comp = sample_format_sel;
      link_nxt.scramble_en = mode_is_64b66b_i || scrambler_enable;
      link_nxt.lane_mask = link_enable_r ?
         lane_mask_f(lane_count_i, upper_lane_map_sel) : '0;
      link_nxt.device_id = link_device_identifier_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped indices read as zero, reserved bits as zero
   wire logic [REG_W-1:0] rd_byte =
      (idx == IDX_LINK_EN) ? {7'h00, link_enable_r} :
      (idx == IDX_SW_SYNC) ? {7'h00, sw_sync_request_n_r} :
      (idx == IDX_CTRL) ? {3'h0, link_control_r} :
      (idx == IDX_TEST) ? {3'h0, test_pattern_sel_r} :
      (idx == IDX_DID) ? link_device_identifier_r :
      (idx == IDX_STATUS) ?
         {6'h00, link_cfg_o.link_reset, sync_request_n_o} :
      8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake and read data
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_r <= 1'b0;
         rd_data_r <= '0;
      end else begin
         ack_r <= req;
         if (req) begin
            rd_data_r <= {24'h000000, rd_byte};
         end
      end
   end

   // Software registers; only the field bits are stored
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         link_enable_r <= RST_LINK_EN[0];
         sw_sync_request_n_r <= RST_SW_SYNC[0];
         link_control_r <= RST_CTRL[CTRL_W-1:0];
         test_pattern_sel_r <= RST_TEST[TEST_W-1:0];
         link_device_identifier_r <= RST_DID;
      end else begin
         if (wr_en) link_enable_r <= wbyte[0];
         if (wr_sync) sw_sync_request_n_r <= wbyte[0];
         if (wr_ctrl) link_control_r <= wbyte[CTRL_W-1:0];
         if (wr_test) test_pattern_sel_r <= wbyte[TEST_W-1:0];
         if (wr_did) link_device_identifier_r <= wbyte;
      end
   end

   // Outputs straight from flip-flops
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_request_n_o <= 1'b1;
         link_cfg_o <= '0;
      end else begin
         sync_request_n_o <= sync_n_nxt;
         link_cfg_o <= link_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_data_r;

   ////////////////////////////////////////////////////////////////////////////
   // Test pattern decoding
   sltx_test_decode u_test_decode (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .code_i(test_pattern_sel_r),
      .test_o(test_cfg_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking dcb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   sequence ctrl_write_fmt0_s;
      wr_ctrl && !wb_dat_i[CTRL_FMT_BIT];
   endsequence
   sequence did_write_s;
      wr_did;
   endsequence

   bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Ack not a single cycle after request");
   sw_sync_a: assert property (!sw_sync_request_n_r |=>
      !sync_request_n_o)
      else $error("Software sync request not asserted");
   pin_hold_a: assert property (sync_src == SYNC_SRC_DEDICATED &&
      !dedicated_sync_n_i |=> !sync_request_n_o)
      else $error("Low dedicated pin did not assert request");
   sw_release_a: assert property (sync_src == SYNC_SRC_SOFTWARE &&
      sw_sync_request_n_r |=> sync_request_n_o)
      else $error("Software only source did not release");
   ts_source_a: assert property (sync_src == SYNC_SRC_TIMESTAMP &&
      timestamp_receiver_enable_i && !timestamp_sync_n_i |=>
      !sync_request_n_o)
      else $error("Timestamp pin did not assert request");
   lane_low_a: assert property (link_enable_r && !upper_lane_map_sel &&
      lane_count_i != 0 |=> link_cfg_o.lane_mask[0])
      else $error("Lane zero unused in lower map");
   lane_high_a: assert property (upper_lane_map_sel |=>
      link_cfg_o.lane_mask[ALT_LANE_BASE-1:0] == '0)
      else $error("Lower lanes used in upper map");
   fmt_write_a: assert property (ctrl_write_fmt0_s |=> ##1
      !link_cfg_o.sample_twos_comp)
      else $error("Offset binary not selected after write");
   scr_8b_a: assert property (!mode_is_64b66b_i && !scrambler_enable |=>
      !link_cfg_o.scramble_en)
      else $error("Scrambler on though disabled");
   scr_64b_a: assert property (mode_is_64b66b_i |=>
      link_cfg_o.scramble_en)
      else $error("64B/66B mode not scrambled");
   did_load_a: assert property (did_write_s |=> ##1
      link_cfg_o.device_id == $past(wb_dat_i[REG_W-1:0], 2))
      else $error("Device identifier not carried to link");
   link_off_a: assert property (!link_enable_r |=>
      link_cfg_o.link_reset && link_cfg_o.mf_counter_hold &&
      link_cfg_o.lane_mask == '0)
      else $error("Disabled link not held in reset");
endmodule
`default_nettype wire

// ==== logic/sltx_pkg.sv ====
// Shared constants and types for the serial link transmit control registers
`default_nettype none
package sltx_pkg;
   // Wishbone geometry: printed offsets are register indices, byte = 4 * index
   localparam int ADR_W = 12;
   localparam int IDX_W = 10;
   localparam int DAT_W = 32;
   localparam int REG_W = 8;
   localparam int LANES = 8;
   localparam int LCNT_W = 4;

   // Register indices
   localparam logic [IDX_W-1:0] IDX_LINK_EN = 10'h200;
   localparam logic [IDX_W-1:0] IDX_SW_SYNC = 10'h203;
   localparam logic [IDX_W-1:0] IDX_CTRL = 10'h204;
   localparam logic [IDX_W-1:0] IDX_TEST = 10'h205;
   localparam logic [IDX_W-1:0] IDX_DID = 10'h206;
   localparam logic [IDX_W-1:0] IDX_STATUS = 10'h20f;

   // Reset values
   localparam logic [REG_W-1:0] RST_LINK_EN = 8'h01;
   localparam logic [REG_W-1:0] RST_SW_SYNC = 8'h01;
   localparam logic [REG_W-1:0] RST_CTRL = 8'h03;
   localparam logic [REG_W-1:0] RST_TEST = 8'h00;
   localparam logic [REG_W-1:0] RST_DID = 8'h00;

   // Field positions
   localparam int CTRL_SCR_BIT = 0;
   localparam int CTRL_FMT_BIT = 1;
   localparam int CTRL_SYNC_LSB = 2;
   localparam int CTRL_ALT_BIT = 4;
   localparam int CTRL_W = 5;
   localparam int TEST_W = 5;
   localparam int STAT_SYNC_BIT = 0;
   localparam int STAT_RST_BIT = 1;

   // Sync source selector values
   localparam logic [1:0] SYNC_SRC_DEDICATED = 2'h0;
   localparam logic [1:0] SYNC_SRC_TIMESTAMP = 2'h1;
   localparam logic [1:0] SYNC_SRC_SOFTWARE = 2'h2;

   // First lane used by the upper lane map
   localparam int ALT_LANE_BASE = 4;

   // Test pattern selector codes
   localparam logic [TEST_W-1:0] TP_NORMAL = 5'h00;
   localparam logic [TEST_W-1:0] TP_PRBS7 = 5'h01;
   localparam logic [TEST_W-1:0] TP_PRBS15 = 5'h02;
   localparam logic [TEST_W-1:0] TP_PRBS23 = 5'h03;
   localparam logic [TEST_W-1:0] TP_RAMP = 5'h04;
   localparam logic [TEST_W-1:0] TP_TRANSPORT = 5'h05;
   localparam logic [TEST_W-1:0] TP_D21_5 = 5'h06;
   localparam logic [TEST_W-1:0] TP_K28_5 = 5'h07;
   localparam logic [TEST_W-1:0] TP_ILA_RPT = 5'h08;
   localparam logic [TEST_W-1:0] TP_RPAT = 5'h09;
   localparam logic [TEST_W-1:0] TP_HOLD_LOW = 5'h0a;
   localparam logic [TEST_W-1:0] TP_HOLD_HIGH = 5'h0b;
   localparam logic [TEST_W-1:0] TP_PRBS9 = 5'h0d;
   localparam logic [TEST_W-1:0] TP_PRBS31 = 5'h0e;
   localparam logic [TEST_W-1:0] TP_CLOCK = 5'h0f;
   localparam logic [TEST_W-1:0] TP_K28_7 = 5'h10;

   // PRBS polynomial orders and clock pattern word
   localparam logic [4:0] PRBS_ORD_7 = 5'h07;
   localparam logic [4:0] PRBS_ORD_9 = 5'h09;
   localparam logic [4:0] PRBS_ORD_15 = 5'h0f;
   localparam logic [4:0] PRBS_ORD_23 = 5'h17;
   localparam logic [4:0] PRBS_ORD_31 = 5'h1f;
   localparam logic [15:0] CLOCK_WORD = 16'h00ff;

   typedef enum logic [3:0] {
      PAT_NORMAL, PAT_PRBS, PAT_RAMP, PAT_TRANSPORT, PAT_D21_5,
      PAT_K28_5, PAT_K28_7, PAT_ILA_RPT, PAT_RPAT, PAT_HOLD_LOW,
      PAT_HOLD_HIGH, PAT_CLOCK
   } sltx_pat_e;

   // Decoded test pattern request for the lane generators
   typedef struct packed {
      sltx_pat_e kind;
      logic [4:0] prbs_order;
      logic [15:0] clock_word;
      logic reserved_code;
      logic needs_8b10b;
   } sltx_test_s;

   // Static link configuration seen by transport and link layers
   typedef struct packed {
      logic link_reset;
      logic serdes_power_down;
      logic clock_gate;
      logic mf_counter_hold;
      logic sample_twos_comp;
      logic scramble_en;
      logic [LANES-1:0] lane_mask;
      logic [REG_W-1:0] device_id;
   } sltx_link_s;
endpackage
`default_nettype wire

// ==== logic/sltx_test_decode.sv ====
// Test pattern selector decoder with registered result
`default_nettype none
module sltx_test_decode
   import sltx_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [TEST_W-1:0] code_i,
   output sltx_test_s test_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode; reserved codes fall back to normal traffic so the lanes stay sane
   sltx_test_s dec;
   always_comb begin
      dec = '0;
      dec.kind = PAT_NORMAL;
      dec.clock_word = CLOCK_WORD;
      case (code_i)
         TP_NORMAL: dec.kind = PAT_NORMAL;
         TP_PRBS7: begin
            dec.kind = PAT_PRBS;
            dec.prbs_order = PRBS_ORD_7;
         end
         TP_PRBS15: begin
            dec.kind = PAT_PRBS;
            dec.prbs_order = PRBS_ORD_15;
         end
         TP_PRBS23: begin
            dec.kind = PAT_PRBS;
            dec.prbs_order = PRBS_ORD_23;
         end
         TP_PRBS9: begin
            dec.kind = PAT_PRBS;
            dec.prbs_order = PRBS_ORD_9;
         end
         TP_PRBS31: begin
            dec.kind = PAT_PRBS;
            dec.prbs_order = PRBS_ORD_31;
         end
         TP_RAMP: dec.kind = PAT_RAMP;
         TP_TRANSPORT: dec.kind = PAT_TRANSPORT;
         TP_D21_5: dec.kind = PAT_D21_5;
         TP_K28_5: begin
            dec.kind = PAT_K28_5;
            dec.needs_8b10b = 1'b1;
         end
         TP_K28_7: begin
            dec.kind = PAT_K28_7;
            dec.needs_8b10b = 1'b1;
         end
         TP_ILA_RPT: begin
            dec.kind = PAT_ILA_RPT;
            dec.needs_8b10b = 1'b1;
         end
         TP_RPAT: begin
            dec.kind = PAT_RPAT;
            dec.needs_8b10b = 1'b1;
         end
         TP_HOLD_LOW: dec.kind = PAT_HOLD_LOW;
         TP_HOLD_HIGH: dec.kind = PAT_HOLD_HIGH;
         TP_CLOCK: dec.kind = PAT_CLOCK;
         default: dec.reserved_code = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered so the output comes straight from a flip-flop
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         test_o <= '0;
      end else begin
         test_o <= dec;
      end
   end

   default clocking dcb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   prbs_low_a: assert property (code_i == TP_PRBS15 |=>
      test_o.kind == PAT_PRBS && test_o.prbs_order == PRBS_ORD_15)
      else $error("PRBS15 code not decoded");
   prbs_high_a: assert property (code_i == TP_PRBS31 |=>
      test_o.kind == PAT_PRBS && test_o.prbs_order == PRBS_ORD_31)
      else $error("PRBS31 code not decoded");
   k_char_a: assert property (code_i == TP_K28_7 |=>
      test_o.kind == PAT_K28_7 && test_o.needs_8b10b)
      else $error("K28.7 code not decoded");
   hold_pins_a: assert property (code_i == TP_HOLD_LOW |=>
      test_o.kind == PAT_HOLD_LOW ##1 $stable(test_o) || code_i != TP_HOLD_LOW)
      else $error("Hold low code not decoded");
endmodule
`default_nettype wire

// ==== verification/sltx_rx_model.sv ====
// Receiver-side model that drives the active-low sync pins
`default_nettype none
module sltx_rx_model (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic want_sync_i,
   input wire logic on_ts_i,
   output logic dedicated_sync_n_o,
   output logic timestamp_sync_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin changes land one edge after the command, like a real receiver
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         dedicated_sync_n_o <= 1'b1;
         timestamp_sync_n_o <= 1'b1;
      end else begin
         dedicated_sync_n_o <= !(want_sync_i && !on_ts_i);
         timestamp_sync_n_o <= !(want_sync_i && on_ts_i);
      end
   end
endmodule
`default_nettype wire

// ==== verification/sltx_ctrl_regs_tb.sv ====
// Self-checking bench for the link transmit control registers
`default_nettype none
module sltx_ctrl_regs_tb import sltx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i;
   logic reset_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [ADR_W-1:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [DAT_W-1:0] dat = '0;
   logic [DAT_W-1:0] rdat;
   logic ack;
   logic ts_en = 1'b0;
   logic m64 = 1'b0;
   logic [LCNT_W-1:0] lcnt = 4'h4;
   logic want = 1'b0;
   logic on_ts = 1'b0;
   logic ded_n;
   logic ts_n;
   logic sreq_n;
   sltx_link_s link;
   sltx_test_s tcfg;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc_cnt = 0;

   ////////////////////////////////////////////////////////////////////////
   sltx_ctrl_regs #(.NUM_LANES(LANES)) u_dut (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .dedicated_sync_n_i(ded_n), .timestamp_sync_n_i(ts_n),
      .timestamp_receiver_enable_i(ts_en), .mode_is_64b66b_i(m64),
      .lane_count_i(lcnt), .sync_request_n_o(sreq_n),
      .link_cfg_o(link), .test_cfg_o(tcfg));
   sltx_rx_model u_rx (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .want_sync_i(want),
      .on_ts_i(on_ts), .dedicated_sync_n_o(ded_n),
      .timestamp_sync_n_o(ts_n));

   // Free-running 50 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   // Hang guard: whole run needs well under 3000 cycles
   always @(posedge sys_clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 6000) begin
         fail_count++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Classic cycle: hold the request until ack is sampled, then release
   task automatic wb_rw(input logic w, input logic [IDX_W-1:0] idx,
                        input logic [7:0] d, output logic [31:0] q);
      @(posedge sys_clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'h1;
      dat <= {24'h0, d};
      do @(posedge sys_clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [31:0] q;
      wb_rw(1'b1, idx, d, q);
   endtask
   task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] e);
      logic [31:0] q;
      wb_rw(1'b0, idx, 8'h00, q);
      check("read", q, {24'h0, e});
   endtask
   // Derived outputs trail a write by two edges; three is a safe margin
   task automatic settle();
      repeat (3) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic sreq(input logic e);
      settle();
      check("sync_n", 32'(sreq_n), 32'(e));
   endtask
   // Config is only touched with the link disabled
   task automatic apply(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      wr(IDX_LINK_EN, 8'h00);
      wr(idx, d);
      wr(IDX_LINK_EN, 8'h01);
      settle();
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(IDX_SW_SYNC, 8'h01);
      rd(IDX_CTRL, 8'h03);
      rd(IDX_TEST, 8'h00);
      rd(IDX_DID, 8'h00);
      wr(10'h3ff, 8'h5a);
      rd(10'h3ff, 8'h00);
      check("mask", 32'(link.lane_mask), 32'h0f);
      check("fmt", 32'(link.sample_twos_comp), 32'h1);
      check("scr", 32'(link.scramble_en), 32'h1);
      check("rst", 32'(link.link_reset), 32'h0);
      sreq(1'b1);
      $display("test reset done");
   endtask
   task automatic t_sync();
      wr(IDX_LINK_EN, 8'h00);
      settle();
      check("hold", {link.link_reset, link.serdes_power_down,
         link.clock_gate, link.mf_counter_hold}, 32'hf);
      wr(IDX_SW_SYNC, 8'h00);
      sreq(1'b0);
      wr(IDX_SW_SYNC, 8'h01);
      sreq(1'b1);
      want <= 1'b1;
      sreq(1'b0);
      wr(IDX_CTRL, 8'h0b);
      sreq(1'b1);
      wr(IDX_SW_SYNC, 8'h00);
      sreq(1'b0);
      wr(IDX_SW_SYNC, 8'h01);
      wr(IDX_CTRL, 8'h07);
      sreq(1'b1);
      on_ts <= 1'b1;
      ts_en <= 1'b1;
      sreq(1'b0);
      ts_en <= 1'b0;
      sreq(1'b1);
      want <= 1'b0;
      wr(IDX_SW_SYNC, 8'h00);
      sreq(1'b0);
      wr(IDX_SW_SYNC, 8'h01);
      on_ts <= 1'b0;
      wr(IDX_CTRL, 8'h03);
      sreq(1'b1);
      $display("test sync done");
   endtask
   task automatic t_lanes();
      apply(IDX_CTRL, 8'h13);
      check("mask", 32'(link.lane_mask), 32'hf0);
      lcnt <= 4'h2;
      settle();
      check("mask", 32'(link.lane_mask), 32'h30);
      apply(IDX_CTRL, 8'h03);
      check("mask", 32'(link.lane_mask), 32'h03);
      lcnt <= 4'h4;
      apply(IDX_CTRL, 8'h00);
      check("fmt", 32'(link.sample_twos_comp), 32'h0);
      check("scr", 32'(link.scramble_en), 32'h0);
      m64 <= 1'b1;
      settle();
      check("scr", 32'(link.scramble_en), 32'h1);
      m64 <= 1'b0;
      apply(IDX_CTRL, 8'h03);
      check("scr", 32'(link.scramble_en), 32'h1);
      $display("test lanes done");
   endtask
   function automatic sltx_pat_e exp_kind(input int c);
      case (c)
         1, 2, 3, 13, 14: return PAT_PRBS;
         4: return PAT_RAMP;
         5: return PAT_TRANSPORT;
         6: return PAT_D21_5;
         7: return PAT_K28_5;
         8: return PAT_ILA_RPT;
         9: return PAT_RPAT;
         10: return PAT_HOLD_LOW;
         11: return PAT_HOLD_HIGH;
         15: return PAT_CLOCK;
         16: return PAT_K28_7;
         default: return PAT_NORMAL;
      endcase
   endfunction
   // Codes 0 to 17 including reserved 12 and 17, all in 8B/10B mode
   task automatic t_test();
      logic [4:0] ord [int];
      ord = '{1: 5'h07, 2: 5'h0f, 3: 5'h17, 13: 5'h09, 14: 5'h1f};
      for (int c = 0; c < 18; c++) begin
         apply(IDX_TEST, 8'(c));
         rd(IDX_TEST, 8'(c));
         check("kind", 32'(tcfg.kind), 32'(exp_kind(c)));
         check("resv", 32'(tcfg.reserved_code),
            32'(c == 12 || c == 17));
         check("k8b", 32'(tcfg.needs_8b10b),
            32'(c inside {7, 8, 9, 16}));
         if (ord.exists(c)) begin
            check("ord", 32'(tcfg.prbs_order), 32'(ord[c]));
         end
         if (c == 15) begin
            check("clk", 32'(tcfg.clock_word), 32'h00ff);
         end
      end
      apply(IDX_TEST, 8'h00);
      $display("test pattern done");
   endtask
   task automatic t_did();
      apply(IDX_DID, 8'ha5);
      check("did", 32'(link.device_id), 32'ha5);
      rd(IDX_DID, 8'ha5);
      // Reserved bits are always written as zero by software
      apply(IDX_SW_SYNC, 8'h00);
      rd(IDX_SW_SYNC, 8'h00);
      sreq(1'b0);
      apply(IDX_SW_SYNC, 8'h01);
      $display("test ident done");
   endtask

   // Main sequence after a 20-cycle reset
   initial begin
      repeat (20) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_sync();
      t_lanes();
      t_test();
      t_did();
      give_verdict();
   end
endmodule
`default_nettype wire
